// >>> inc/chan_cfg.svh
// Purpose: Offsets, field positions, reset values and decode constants
// Assumes: 8-bit register port, byte offsets as printed
// Notes:   Voltages are expressed in units of 0.5 mV
`ifndef CHAN_CFG_SVH
`define CHAN_CFG_SVH

`define OFS_CH1_TARGET_VOLTAGE 8'h0A
`define OFS_CH1_DISCHARGE_ENABLE 8'h0B
`define OFS_CH2_TARGET_VOLTAGE 8'h0C
`define OFS_CH1_CONFIG_C 8'h0F
`define RST_TARGET 8'h00
`define RST_DISCHARGE_ENABLE 8'h00
`define RST_CONFIG_C 8'h00
`define BIT_DISCHARGE 3
`define BIT_STEP_SELECT 2
`define MSB_ENABLE_SELECT 2
// Base 0.5 V and steps in 0.5 mV units
`define MV_BASE_HALF 14'h03E8
`define MV_STEP_FINE_HALF 14'h0019
`define MV_STEP_COARSE_HALF 14'h0032
`define CODE_COARSE_MAX 8'hC8

`endif

// >>> inc/chan_pkg.sv
// Purpose: Types for the regulator channel register bank
// Assumes: None
// Notes:   Constants live in the cfg header
package chan_pkg;
  typedef enum logic [1:0] {
    EN_SLOT,
    EN_OFF,
    EN_ON
  } enable_kind_t;
endpackage

// >>> verilog/regulator_channel_config_regs.sv
// Purpose: Configuration registers and decode for one regulator channel
// Assumes: Host interface logic supplies decoded byte writes and reads
// Notes:   Outputs are registered; voltage in 0.5 mV units
//          A low clock enable freezes every register, decoded outputs too
//          Reserved target codes are flagged, never blocked or clamped
//          The step select bit is copied only on a target code write
//          Enable select codes 6 and 7 behave alike, as do 4 and 5
//
// Summary of operation
// - With coarse steps the target voltage is 0.5 V plus code times 25 mV up to 0xC8.
// - With fine steps every code gives 0.5 V plus code times 12.5 mV.
// - With discharge disabled a disabled channel leaves its output undriven.
// - With discharge enabled a disabled channel switches the discharge resistor on.
// - A step-size change takes effect only on the next target code write.
//
// Register map, byte offsets
//   0x0A  ch1 target code, all eight bits
//   0x0B  ch1 discharge enable in bit 3, enable select in bits 2:0
//   0x0C  ch2 target code, all eight bits
//   0x0F  ch1 config c, step select in bit 2, other bits plain storage
//
// Decoded outputs trail a register write by one further edge, so the
// analog side only ever sees levels that were settled for a whole cycle.
`timescale 1ns/100ps
`default_nettype none
`include "chan_cfg.svh"

module regulator_channel_config_regs (
  // Clock and control
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic                 ce,
  // Register port
  input  wire logic                 wr_en,
  input  wire logic                 rd_en,
  input  wire logic [7:0]           addr,
  input  wire logic [7:0]           wdata,
  output var  logic [7:0]           rdata,
  output var  logic                 rd_valid,
  // Sequencer status, one bit for each of the four slots
  input  wire logic [3:0]           sequencer_slot_on,
  // Analog controls
  output var  logic [13:0]          ch1_target_halfmv,
  output var  logic                 ch1_code_reserved,
  output var  logic                 ch1_on,
  output var  logic                 ch1_discharge_on,
  output var  logic [1:0]           ch1_slot,
  output var  chan_pkg::enable_kind_t ch1_enable_kind,
  output var  logic [7:0]           ch2_target_code
);
  import chan_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Decode helpers
  // Enable select to kind; the slot number itself is taken from bits 1:0
  // by the caller, so this only has to tell slot, off and on apart
  function automatic enable_kind_t kind_of(input logic [2:0] sel);
    case (sel)
      3'h0, 3'h1, 3'h2, 3'h3: kind_of = EN_SLOT;
      3'h4, 3'h5: kind_of = EN_OFF;
      default: kind_of = EN_ON;                 // 6 and 7 both force on
    endcase
  endfunction

  // Widest result is 1000 + 255 * 50 = 13750, inside 14 bits, no wrap
  function automatic logic [13:0] volts(input logic [7:0] code, input logic fine);
    volts = `MV_BASE_HALF + 14'(code) *
            (fine ? `MV_STEP_FINE_HALF : `MV_STEP_COARSE_HALF);
  endfunction

  // Address decode, shared by the write path and the read mux so the two
  // can never disagree about which offsets exist
  function automatic logic [2:0] reg_sel(input logic [7:0] a);
    case (a)
      `OFS_CH1_TARGET_VOLTAGE:   reg_sel = 3'h0;
      `OFS_CH1_DISCHARGE_ENABLE: reg_sel = 3'h1;
      `OFS_CH2_TARGET_VOLTAGE:   reg_sel = 3'h2;
      `OFS_CH1_CONFIG_C:         reg_sel = 3'h3;
      default:                   reg_sel = 3'h4; // Unmapped
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Register state
  // The applied step bit is kept apart from config c so that software can
  // stage a new step size and have it land together with the next code
  logic [7:0] ch1_target_code, next_ch1_target_code;
  logic [7:0] ch1_discharge_and_enable, next_ch1_discharge_and_enable;
  logic [7:0] ch1_config_c, next_ch1_config_c;
  logic [7:0] next_ch2_target_code;
  logic       applied_step, next_applied_step;
  logic [7:0] next_rdata;
  logic       next_rd_valid;

  // Register writes and read mux
  always_comb begin
    next_ch1_target_code          = ch1_target_code;
    next_ch1_discharge_and_enable = ch1_discharge_and_enable;
    next_ch1_config_c             = ch1_config_c;
    next_ch2_target_code          = ch2_target_code;
    next_applied_step             = applied_step;
    next_rdata                    = 8'h00;
    next_rd_valid                 = rd_en;
    if (wr_en) begin
      case (reg_sel(addr))
        3'h0: begin
          next_ch1_target_code = wdata;
          // Step bit sampled only here, so a step change waits for this write
          next_applied_step    = ch1_config_c[`BIT_STEP_SELECT];
        end
        // Upper nibble has no storage and reads back zero
        3'h1: next_ch1_discharge_and_enable = {4'h0, wdata[3:0]};
        3'h2: next_ch2_target_code = wdata;
        3'h3: next_ch1_config_c = wdata;
        default: ;
      endcase
    end
    // Unmapped addresses read zero; a read in a write cycle sees old data
    case (reg_sel(addr))
      3'h0: next_rdata = ch1_target_code;
      3'h1: next_rdata = ch1_discharge_and_enable;
      3'h2: next_rdata = ch2_target_code;
      3'h3: next_rdata = ch1_config_c;
      default: next_rdata = 8'h00;
    endcase
    // Read data holds between reads so a slow host may sample it late
    if (!rd_en) next_rdata = rdata;
  end

  // Register file; reset wins over a frozen clock enable so a host can
  // always bring the bank back to a known state
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ch1_target_code          <= `RST_TARGET;
      ch1_discharge_and_enable <= `RST_DISCHARGE_ENABLE;
      ch1_config_c             <= `RST_CONFIG_C;
      ch2_target_code          <= `RST_TARGET;
      applied_step             <= 1'b0;
      rdata                    <= 8'h00;
      rd_valid                 <= 1'b0;
    end else if (ce) begin
      ch1_target_code          <= next_ch1_target_code;
      ch1_discharge_and_enable <= next_ch1_discharge_and_enable;
      ch1_config_c             <= next_ch1_config_c;
      ch2_target_code          <= next_ch2_target_code;
      applied_step             <= next_applied_step;
      rdata                    <= next_rdata;
      rd_valid                 <= next_rd_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output decode, registered so analog sees clean levels
  logic [13:0]  next_ch1_target_halfmv;
  logic         next_ch1_code_reserved;
  logic         next_ch1_on;
  logic         next_ch1_discharge_on;
  logic [1:0]   next_ch1_slot;
  enable_kind_t next_ch1_enable_kind;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer slot match, one line per slot
  // Only the selected slot can pass its state, so the OR of all lines is
  // the state of that slot without a wide index mux
  logic [3:0] slot_hit;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_slot
      assign slot_hit[g] = (ch1_discharge_and_enable[1:0] == 2'(g)) &&
                           sequencer_slot_on[g];
    end
  endgenerate

  // Decoded levels for the analog side

  always_comb begin
    next_ch1_target_halfmv = volts(ch1_target_code, applied_step);
    // Flag only; software is expected to avoid these codes
    next_ch1_code_reserved = !applied_step && (ch1_target_code > `CODE_COARSE_MAX);
    next_ch1_enable_kind   = kind_of(ch1_discharge_and_enable[`MSB_ENABLE_SELECT:0]);
    next_ch1_slot          = ch1_discharge_and_enable[1:0];
    case (next_ch1_enable_kind)
      EN_SLOT: next_ch1_on = |slot_hit;
      EN_OFF:  next_ch1_on = 1'b0;
      EN_ON:   next_ch1_on = 1'b1;
      default: next_ch1_on = 1'b0;
    endcase
    // Off without discharge leaves output floating
    next_ch1_discharge_on = !next_ch1_on && ch1_discharge_and_enable[`BIT_DISCHARGE];
  end

  // Output flops; reset shows the base voltage with the channel off, so
  // the analog side never sees a code it was not given
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ch1_target_halfmv <= `MV_BASE_HALF;
      ch1_code_reserved <= 1'b0;
      ch1_on            <= 1'b0;
      ch1_discharge_on  <= 1'b0;
      ch1_slot          <= 2'h0;
      ch1_enable_kind   <= EN_SLOT;
    end else if (ce) begin
      ch1_target_halfmv <= next_ch1_target_halfmv;
      ch1_code_reserved <= next_ch1_code_reserved;
      ch1_on            <= next_ch1_on;
      ch1_discharge_on  <= next_ch1_discharge_on;
      ch1_slot          <= next_ch1_slot;
      ch1_enable_kind   <= next_ch1_enable_kind;
    end
  end

endmodule // regulator_channel_config_regs

`default_nettype wire

// >>> tb/chan_host_model.sv
// Purpose: Host model issuing byte writes and reads
// Assumes: Strobes change on falling edges
// Notes:   Released lines show inverted data
`timescale 1ns/100ps
`default_nettype none
module chan_host_model (
  // Register port
  input  wire logic       clk,
  output var  logic       wr_en,
  output var  logic       rd_en,
  output var  logic [7:0] addr,
  output var  logic [7:0] wdata
);
  initial {wr_en, rd_en, addr, wdata} = '0;
  // One strobe held over one rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {wr_en, rd_en, addr, wdata} = {w, !w, a, d};
    @(negedge clk);
    {wr_en, rd_en, addr, wdata} = {2'b00, ~addr, ~wdata};
  endtask
  // Reserved band is never sent with coarse steps
  function automatic logic [7:0] legal(input logic [7:0] c, input logic fine);
    return (fine || c <= 8'hC8) ? c : c - 8'h37;
  endfunction
endmodule // chan_host_model
`default_nettype wire

// >>> tb/chan_cfg_props.sv
// Purpose: Port-level checks of the channel register decode
// Assumes: Decoded outputs lag a write by two edges
// Notes:   Step and discharge bits shadowed here
`timescale 1ns/100ps
`default_nettype none
module chan_cfg_checker
  import chan_pkg::*;
(
  input wire logic clk, rstn, ce, wr_en, ch1_on, ch1_discharge_on,
  input wire logic [7:0] addr, wdata,
  input wire logic [13:0] ch1_target_halfmv,
  input wire logic [1:0] ch1_slot,
  input wire enable_kind_t ch1_enable_kind
);
  logic fine, dis;
  wire logic wr = wr_en && ce;
  // Shadow copies, needed because the bits sit behind the ports
  always_ff @(posedge clk)
    if (!rstn) {fine, dis} <= 2'b00;
    else if (wr && addr == 8'h0F) fine <= wdata[2];
    else if (wr && addr == 8'h0B) dis <= wdata[3];
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_coarse; wr && addr == 8'h0A && !fine |->
    ##2 ch1_target_halfmv == 14'h03E8 + 14'($past(wdata, 2)) * 14'h0032; endproperty
  a_coarse: assert property (p_coarse) else $error("coarse decode wrong");
  property p_fine; wr && addr == 8'h0A && fine |->
    ##2 ch1_target_halfmv == 14'h03E8 + 14'($past(wdata, 2)) * 14'h0019; endproperty
  a_fine: assert property (p_fine) else $error("fine decode wrong");
  property p_hold; wr && addr == 8'h0F |-> ##3 $stable(ch1_target_halfmv); endproperty
  a_hold: assert property (p_hold) else $error("step applied early");
  property p_dis; ch1_discharge_on == ($past(dis) && !ch1_on); endproperty
  a_dis: assert property (p_dis) else $error("discharge switch wrong");
  property p_kind; wr && addr == 8'h0B |-> ##2 ch1_enable_kind ==
    (!$past(wdata[2], 2) ? EN_SLOT : $past(wdata[1], 2) ? EN_ON : EN_OFF); endproperty
  a_kind: assert property (p_kind) else $error("enable kind wrong");
  property p_on; ch1_enable_kind != EN_SLOT |-> ch1_on == (ch1_enable_kind == EN_ON); endproperty
  a_on: assert property (p_on) else $error("forced state wrong");
  property p_slot; wr && addr == 8'h0B && !wdata[2] |-> ##2 ch1_slot == $past(wdata[1:0], 2);
  endproperty
  a_slot: assert property (p_slot) else $error("slot wrong");
  c_fine: cover property (wr && addr == 8'h0A && fine);
  c_dis: cover property (ch1_discharge_on);
  c_on: cover property (ch1_enable_kind == EN_ON);
endmodule // chan_cfg_checker
bind regulator_channel_config_regs chan_cfg_checker chk_u (.clk, .rstn, .ce, .wr_en, .ch1_on,
  .ch1_discharge_on, .addr, .wdata, .ch1_target_halfmv, .ch1_slot, .ch1_enable_kind);
`default_nettype wire

// >>> tb/regulator_channel_config_regs_test.sv
// Purpose: Self-checking bench for the channel registers
// Assumes: Clock enable held high except for one write made with it low
// Notes:   Reads are scored from a queue
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module regulator_channel_config_regs_test;
  logic clk = 0, rstn = 0, ce = 1;
  logic [7:0] exp_rd;
  logic [3:0] slots = '0;
  wire logic wr_en, rd_en, rd_valid, on, dis_on, rsv;
  wire logic [7:0] addr, wdata, rdata, ch2;
  wire logic [13:0] mv;
  wire logic [1:0] slot;
  chan_pkg::enable_kind_t kind;
  int compares = 0, miscompares = 0, cyc = 0, seed = 90760;
  logic [7:0] q[$], c;
  logic [7:0] ad[5] = '{8'h0A, 8'h0B, 8'h0C, 8'h0F, 8'h30};
  chan_host_model host_u (.clk, .wr_en, .rd_en, .addr, .wdata);
  regulator_channel_config_regs dut_u (.clk, .rstn, .ce, .wr_en, .rd_en, .addr, .wdata,
    .rdata, .rd_valid, .sequencer_slot_on(slots), .ch1_target_halfmv(mv),
    .ch1_code_reserved(rsv), .ch1_on(on), .ch1_discharge_on(dis_on), .ch1_slot(slot),
    .ch1_enable_kind(kind), .ch2_target_code(ch2));
  initial forever #4 clk = ~clk;
  // Note the expected byte, then read
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    q.push_back(e);
    host_u.xfer(1'b0, a, 8'h00);
  endtask
  task automatic tally_and_finish;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Score read data; cut a hang short
  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      exp_rd = q.pop_front();
      `CHK(rdata, exp_rd)
    end
    if (++cyc > 3000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (6) @(negedge clk);
    rstn = 1;
    foreach (ad[i]) rd(ad[i], 8'h00);
    host_u.xfer(1'b1, 8'h30, 8'hFF);
    rd(8'h30, 8'h00);
    $display("reset and unmapped done");
    for (int i = 0; i < 16; i++) begin
      slots = 4'($random(seed));
      host_u.xfer(1'b1, 8'h0B, 8'hF0 | 8'(i));
      rd(8'h0B, 8'(i));
      if (i[2:1] == 2'b10) `CHK({on, dis_on}, {1'b0, i[3]})
      if (i[2:1] == 2'b11) `CHK({on, dis_on}, 2'b10)
      if (!i[2]) `CHK(on, slots[i[1:0]])
    end
    $display("enable codes done");
    for (int i = 0; i < 8; i++) begin
      c = i ? host_u.legal(8'($random(seed)), 1'b0) : 8'hC8;
      host_u.xfer(1'b1, 8'h0A, c);
      rd(8'h0A, c);
      `CHK(mv, 14'h03E8 + 14'(c) * 14'h0032)
      `CHK(rsv, 1'b0)
    end
    host_u.xfer(1'b1, 8'h0F, 8'h04);
    rd(8'h0F, 8'h04);
    `CHK(mv, 14'h03E8 + 14'(c) * 14'h0032)
    host_u.xfer(1'b1, 8'h0A, 8'hFF);
    host_u.xfer(1'b1, 8'h0C, 8'hA5);
    `CHK(mv, 14'h03E8 + 14'h00FF * 14'h0019)
    `CHK(ch2, 8'hA5)
    `CHK(rsv, 1'b0)
    ce = 1'b0;
    host_u.xfer(1'b1, 8'h0C, 8'h5A);
    ce = 1'b1;
    `CHK(ch2, 8'hA5)
    $display("decode done");
    tally_and_finish();
  end
endmodule // regulator_channel_config_regs_test
`default_nettype wire
